//--- logic/sleep_wake_map.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by its bare name; 8-bit register port.
// Notes: Definitions only.
`ifndef SLEEP_WAKE_MAP_SVH
`define SLEEP_WAKE_MAP_SVH
// ==========================================================
// Register offsets
`define REG_STATUS 4'h0
`define REG_CTRL 4'h1
`define REG_CMD 4'h2
`define REG_PORT 4'h3
`define REG_CMP1 4'h4
`define REG_CMP2 4'h5
// ==========================================================
// Field positions
`define ST_PIN_WAKE 7
`define ST_CMP_WAKE 6
`define ST_TIMEOUT 4
`define ST_POWERDOWN 3
`define CT_WDT_EN 0
`define CT_PIN_WAKE_EN 1
`define CT_CMP_WAKE_EN 2
`define CT_CODE_PROT 3
`define CM_SLEEP 0
`define CM_CLRWDT 1
// ==========================================================
// Reset values
`define CTRL_RST 8'h01
`define SYNC_RST 8'h01
// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define WDT_PERIOD_NS 18000000
`define CORE_RST_CYCLES 3'h4
// ==========================================================
// Serial programming
`define PCMD_LOAD 6'h02
`define PCMD_READ 6'h04
`define PCMD_INC 6'h06
`define PCMD_PROG 6'h08
`define FREE_READ_LIMIT 11'h040
`define CAL_ADDR 11'h3FF
`define ID_BASE 11'h400
`define ID_UPPER 4'hF
`endif

//--- logic/sleep_wake_pkg.sv
// Purpose: Types shared by the sleep/wake block.
// Assumes: Nothing.
// Notes: Constants live in the map header.
package sleep_wake_pkg;
  typedef enum logic {PS_CMD, PS_DATA} prog_phase_t;
  typedef logic [11:0] prog_word_t;
endpackage : sleep_wake_pkg

//--- logic/sleep_wake_reset_cause.sv
// Purpose: Sleep entry, wake-up, reset cause flags, serial program mode.
// Assumes: 40 MHz clk; all pins asynchronous to clk.
// Notes: Core reset is a flopped output held for a short count.
// Functional notes
// - Watchdog wake from sleep leaves all four cause flags at zero.
// - Watchdog timeout awake clears timeout and wake flags, keeps powerdown.
// - Reset pin clears wake flags; timeout and powerdown unchanged.
// - Power-up sets timeout and powerdown, clears wake flags.
// - Pin-change wake sets pin flag, clears comparator flag.
// - Comparator wake sets comparator flag, clears pin flag.
// - Sleep clears watchdog, sets timeout, clears powerdown, stops oscillator.
// - Port pins hold their drive state while asleep.
// - Watchdog reset never drives the reset pin low.
// - Enabled change on four wake pins wakes through reset.
// - Enabled comparator output change wakes through reset.
// - Pin changes compare to last port read; stale mismatch wakes at once.
// - Comparator changes compare to last comparator config read.
// - Watchdog counter clears on every wake.
// - Protected parts read first 64 words and calibration word only.
// - Four ID words, program mode only, readable despite protection.
// - Program mode uses pins as serial clock and data.
// - Six-bit command, then fourteen data bits for load or read.
`timescale 1ns/1ps
`include "sleep_wake_map.svh"
module sleep_wake_reset_cause
  import sleep_wake_pkg::*;
#(
  parameter int WDT_CYCLES = `WDT_PERIOD_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Pins and comparator outputs
  input wire logic external_reset_pin_n,
  input wire logic prog_data_pin,
  input wire logic prog_clock_pin,
  input wire logic reset_capable_input_pin,
  input wire logic extra_wake_pin,
  input wire logic comparator1_output,
  input wire logic comparator2_output,
  input wire logic program_entry_high_level,
  // Serial data drive
  output logic prog_data_out_q,
  output logic prog_data_oe_q,
  // Reset pin drive
  output logic reset_pin_oe_q,
  // Core controls
  output logic core_rst_q,
  output logic osc_en_q,
  output logic port_hold_q,
  output logic sleep_q,
  output logic prog_mode_q
);
  // ==========================================================
  // Input synchronisers
  logic [7:0] async_raw;
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  assign async_raw = {program_entry_high_level, comparator2_output,
                      comparator1_output, extra_wake_pin,
                      reset_capable_input_pin, prog_clock_pin,
                      prog_data_pin, external_reset_pin_n};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= `SYNC_RST;
      sync_q <= `SYNC_RST;
    end else begin
      meta_q <= async_raw;
      sync_q <= meta_q;
    end
  end
  wire ext_rst = !sync_q[0];
  wire [3:0] wake_pins = sync_q[4:1];
  wire [1:0] cmp_out = sync_q[6:5];
  wire vpp_high = sync_q[7];
  wire pdata_in = sync_q[1];
  wire pclk_in = sync_q[2];
  // ==========================================================
  // Registers and decode
  logic [7:0] ctrl_q;
  logic timeout_flag_n_q, powerdown_flag_n_q;
  logic pin_wake_flag_q, comparator_wake_flag_q;
  logic [3:0] pin_snap_q;
  logic [1:0] cmp_snap_q;
  logic [7:0] rdata_d;
  logic [7:0] status_val;
  wire wr_ctrl = reg_wr && reg_addr == `REG_CTRL;
  wire wr_cmd = reg_wr && reg_addr == `REG_CMD;
  wire rd_port = reg_rd && reg_addr == `REG_PORT;
  wire rd_cmp1 = reg_rd && reg_addr == `REG_CMP1;
  wire rd_cmp2 = reg_rd && reg_addr == `REG_CMP2;
  wire wdt_en = ctrl_q[`CT_WDT_EN];
  wire pin_wake_en = ctrl_q[`CT_PIN_WAKE_EN];
  wire cmp_wake_en = ctrl_q[`CT_CMP_WAKE_EN];
  wire code_prot = ctrl_q[`CT_CODE_PROT];
  logic [19:0] wdt_cnt_q;
  wire wdt_to = wdt_en && !prog_mode_q && wdt_cnt_q == 20'(WDT_CYCLES - 1);
  // A reset in the same cycle cancels the sleep command
  wire sleep_go = wr_cmd && reg_wdata[`CM_SLEEP] && !sleep_q && !prog_mode_q &&
                  !ext_rst && !wdt_to;
  wire clrwdt = wr_cmd && reg_wdata[`CM_CLRWDT];
  // Flags have no write path at all
  assign status_val = {pin_wake_flag_q, comparator_wake_flag_q, 1'b0,
                       timeout_flag_n_q, powerdown_flag_n_q, 3'h0};
  assign rdata_d = (reg_addr == `REG_STATUS) ? status_val :
                   (reg_addr == `REG_CTRL) ? ctrl_q :
                   (reg_addr == `REG_PORT) ? {4'h0, wake_pins} :
                   (reg_addr == `REG_CMP1) ? {7'h00, cmp_out[0]} :
                   (reg_addr == `REG_CMP2) ? {7'h00, cmp_out[1]} : 8'h00;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
      ctrl_q <= `CTRL_RST;
    end else begin
      reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
      if (wr_ctrl) ctrl_q <= reg_wdata;
    end
  end
  // ==========================================================
  // Change snapshots
  // Snapshot follows each read, so software must read just before sleep
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_snap_q <= 4'h0;
      cmp_snap_q <= 2'h0;
    end else begin
      if (rd_port) pin_snap_q <= wake_pins;
      if (rd_cmp1) cmp_snap_q[0] <= cmp_out[0];
      if (rd_cmp2) cmp_snap_q[1] <= cmp_out[1];
    end
  end
  wire pin_chg = pin_wake_en && wake_pins != pin_snap_q;
  wire cmp_chg = cmp_wake_en && cmp_out != cmp_snap_q;
  wire pin_wake = sleep_q && !ext_rst && !wdt_to && pin_chg;
  wire cmp_wake = sleep_q && !ext_rst && !wdt_to && !pin_chg && cmp_chg;
  wire any_wake = sleep_q && (ext_rst || wdt_to || pin_chg || cmp_chg);
  // ==========================================================
  // Watchdog counter
  wire wdt_clr = clrwdt || sleep_go || any_wake || ext_rst || prog_mode_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_cnt_q <= 20'h00000;
    end else if (wdt_clr || wdt_to) begin
      wdt_cnt_q <= 20'h00000;
    end else if (wdt_en) begin
      wdt_cnt_q <= wdt_cnt_q + 20'h00001;
    end
  end
  // ==========================================================
  // Cause flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_flag_n_q <= 1'b1;
      powerdown_flag_n_q <= 1'b1;
      pin_wake_flag_q <= 1'b0;
      comparator_wake_flag_q <= 1'b0;
    end else if (ext_rst) begin
      pin_wake_flag_q <= 1'b0;
      comparator_wake_flag_q <= 1'b0;
    end else if (wdt_to) begin
      timeout_flag_n_q <= 1'b0;
      pin_wake_flag_q <= 1'b0;
      comparator_wake_flag_q <= 1'b0;
    end else if (pin_wake) begin
      pin_wake_flag_q <= 1'b1;
      comparator_wake_flag_q <= 1'b0;
    end else if (cmp_wake) begin
      comparator_wake_flag_q <= 1'b1;
      pin_wake_flag_q <= 1'b0;
    end else if (sleep_go) begin
      timeout_flag_n_q <= 1'b1;
      powerdown_flag_n_q <= 1'b0;
    end
  end
  // ==========================================================
  // Sleep state and core reset
  logic [2:0] rst_cnt_q;
  wire rst_req = any_wake || wdt_to || ext_rst || prog_mode_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_q <= 1'b0;
      osc_en_q <= 1'b1;
      port_hold_q <= 1'b0;
      core_rst_q <= 1'b1;
      rst_cnt_q <= `CORE_RST_CYCLES;
      reset_pin_oe_q <= 1'b0;
    end else begin
      reset_pin_oe_q <= 1'b0;
      if (any_wake) begin
        sleep_q <= 1'b0;
        osc_en_q <= 1'b1;
        port_hold_q <= 1'b0;
      end else if (sleep_go) begin
        sleep_q <= 1'b1;
        osc_en_q <= 1'b0;
        port_hold_q <= 1'b1;
      end
      if (rst_req) begin
        core_rst_q <= 1'b1;
        rst_cnt_q <= `CORE_RST_CYCLES;
      end else if (rst_cnt_q != 3'h0) begin
        rst_cnt_q <= rst_cnt_q - 3'h1;
      end else begin
        core_rst_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Program mode entry and serial engine
  logic vpp_prev_q, pclk_prev_q;
  prog_phase_t phase_q;
  logic [4:0] bit_cnt_q;
  logic [13:0] shift_q;
  logic [5:0] pcmd_q;
  logic [10:0] paddr_q;
  prog_word_t latch_q;
  prog_word_t prog_mem [0:1023];
  logic [3:0] id_mem [0:3];
  wire entry = vpp_high && !vpp_prev_q && !pclk_in && !pdata_in;
  wire pclk_rise = pclk_in && !pclk_prev_q;
  wire pclk_fall = !pclk_in && pclk_prev_q;
  wire [5:0] cmd_next = {pdata_in, shift_q[13:9]};
  wire in_mem = !paddr_q[10];
  wire in_id = {paddr_q[10:2], 2'h0} == `ID_BASE;
  wire readable = !code_prot || paddr_q < `FREE_READ_LIMIT ||
                  paddr_q == `CAL_ADDR;
  prog_word_t rd_word;
  assign rd_word = (in_mem && readable) ? prog_mem[paddr_q[9:0]] :
                   in_id ? {4'h0, `ID_UPPER, id_mem[paddr_q[1:0]]} :
                   12'h000;
  wire cmd_done = prog_mode_q && phase_q == PS_CMD && pclk_fall &&
                  bit_cnt_q == 5'h05;
  wire data_done = prog_mode_q && phase_q == PS_DATA && pclk_fall &&
                   bit_cnt_q == 5'h0D;
  wire do_prog = cmd_done && cmd_next == `PCMD_PROG;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vpp_prev_q <= 1'b0;
      pclk_prev_q <= 1'b0;
      prog_mode_q <= 1'b0;
    end else begin
      vpp_prev_q <= vpp_high;
      pclk_prev_q <= pclk_in;
      if (!vpp_high) prog_mode_q <= 1'b0;
      else if (entry) prog_mode_q <= 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= PS_CMD;
      bit_cnt_q <= 5'h00;
      shift_q <= 14'h0000;
      pcmd_q <= 6'h00;
      paddr_q <= 11'h000;
      latch_q <= 12'h000;
      prog_data_out_q <= 1'b0;
      prog_data_oe_q <= 1'b0;
    end else if (!prog_mode_q) begin
      phase_q <= PS_CMD;
      bit_cnt_q <= 5'h00;
      paddr_q <= 11'h000;
      prog_data_oe_q <= 1'b0;
    end else begin
      if (pclk_rise && phase_q == PS_DATA && pcmd_q == `PCMD_READ) begin
        prog_data_out_q <= shift_q[0];
        prog_data_oe_q <= 1'b1;
      end
      if (pclk_fall) begin
        shift_q <= {pdata_in, shift_q[13:1]};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      case (phase_q)
        PS_CMD: begin
          if (cmd_done) begin
            pcmd_q <= cmd_next;
            bit_cnt_q <= 5'h00;
            if (cmd_next == `PCMD_INC) paddr_q <= paddr_q + 11'h001;
            if (cmd_next == `PCMD_LOAD || cmd_next == `PCMD_READ) begin
              phase_q <= PS_DATA;
              shift_q <= {1'b0, rd_word, 1'b0};
            end
          end
        end
        PS_DATA: begin
          if (data_done) begin
            phase_q <= PS_CMD;
            bit_cnt_q <= 5'h00;
            prog_data_oe_q <= 1'b0;
            if (pcmd_q == `PCMD_LOAD) latch_q <= shift_q[13:2];
          end
        end
        default: phase_q <= PS_CMD;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (do_prog && in_mem) prog_mem[paddr_q[9:0]] <= latch_q;
    if (do_prog && in_id) id_mem[paddr_q[1:0]] <= latch_q[3:0];
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_wdt_sleep;
    wdt_to && sleep_q && !ext_rst |=> !timeout_flag_n_q && !powerdown_flag_n_q
      && !pin_wake_flag_q && !comparator_wake_flag_q;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("wdt sleep flags");
  property p_wdt_awake;
    wdt_to && !sleep_q && !ext_rst |=> !timeout_flag_n_q &&
      powerdown_flag_n_q == $past(powerdown_flag_n_q) && !pin_wake_flag_q;
  endproperty
  a_wdt_awake: assert property (p_wdt_awake) else $error("wdt awake flags");
  property p_ext;
    ext_rst |=> !pin_wake_flag_q && !comparator_wake_flag_q &&
      $stable(timeout_flag_n_q) && $stable(powerdown_flag_n_q) && core_rst_q;
  endproperty
  a_ext: assert property (p_ext) else $error("reset pin flags");
  property p_sleep;
    sleep_go |=> sleep_q && timeout_flag_n_q && !powerdown_flag_n_q &&
      wdt_cnt_q == 20'h00000 && !osc_en_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry");
  property p_pin;
    pin_wake |=> pin_wake_flag_q && !comparator_wake_flag_q && !sleep_q
      ##1 core_rst_q;
  endproperty
  a_pin: assert property (p_pin) else $error("pin wake");
  property p_cmp;
    cmp_wake |=> comparator_wake_flag_q && !pin_wake_flag_q &&
      !powerdown_flag_n_q && core_rst_q;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator wake");
  property p_wake_wdt;
    any_wake |=> wdt_cnt_q == 20'h00000 && !sleep_q;
  endproperty
  a_wake_wdt: assert property (p_wake_wdt) else $error("wdt not cleared");
  property p_hold;
    sleep_q |-> port_hold_q && !osc_en_q;
  endproperty
  a_hold: assert property (p_hold) else $error("ports not held");
  property p_pin_oe;
    wdt_to |=> !reset_pin_oe_q [*4];
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("reset pin driven");
  property p_protect;
    code_prot && in_mem && paddr_q >= `FREE_READ_LIMIT &&
      paddr_q != `CAL_ADDR |-> rd_word == 12'h000;
  endproperty
  a_protect: assert property (p_protect) else $error("protected read");
  property p_status_rd;
    reg_rd && reg_addr == `REG_STATUS |=> reg_rdata_q == $past(status_val);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read");
  c_wdt_wake: cover property (sleep_q && wdt_to);
  c_pin_wake: cover property (pin_wake);
  c_cmp_wake: cover property (cmp_wake);
  c_prog_read: cover property (data_done && pcmd_q == `PCMD_READ);
endmodule : sleep_wake_reset_cause

//--- tb/far_side.sv
// Purpose: Far-side model: reset pin, wake pins, comparators, serial programmer.
// Assumes: Serial clock period 200 ns, still outside frames.
// Notes: Undriven data line shows the inverse of the last driven level.
`timescale 1ns/1ps
module far_side (
  // Clock
  input wire logic clk,
  // Device drive of the data line
  input wire logic dev_out,
  input wire logic dev_oe,
  // Pins
  output logic rst_pin_n,
  output wire logic data_wire,
  output wire logic clock_pin,
  output wire logic rc_pin,
  output wire logic extra_pin,
  output logic [1:0] cmp,
  output logic entry_hi
);
  logic [3:0] pins;
  logic far_oe;
  assign data_wire = dev_oe ? dev_out : (far_oe ? pins[0] : ~pins[0]);
  assign clock_pin = pins[1];
  assign rc_pin = pins[2];
  assign extra_pin = pins[3];
  initial begin
    pins = 4'h0;
    rst_pin_n = 1'b1;
    cmp = 2'h0;
    entry_hi = 1'b0;
    far_oe = 1'b1;
  end
  // ==========================================================
  // Pin events
  task automatic pin_set(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
  endtask : pin_set
  task automatic cmp_set(input int i, input logic v);
    @(posedge clk);
    cmp[i] <= v;
  endtask : cmp_set
  task automatic rst_pulse();
    @(posedge clk);
    rst_pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_pin_n <= 1'b1;
  endtask : rst_pulse
  // Clock and data held low across the rise of the entry level
  task automatic enter();
    pins[1:0] = 2'h0;
    #107 entry_hi = 1'b1;
  endtask : enter
  task automatic leave();
    #107 entry_hi = 1'b0;
  endtask : leave
  // ==========================================================
  // Serial framing, sampled by the device on the falling clock
  task automatic sbit(input logic b);
    pins[0] = b;
    #50 pins[1] = 1'b1;
    #100 pins[1] = 1'b0;
    #50;
  endtask : sbit
  task automatic cmd(input logic [5:0] c);
    for (int k = 0; k < 6; k++) sbit(c[k]);
  endtask : cmd
  task automatic load(input logic [11:0] d);
    logic [13:0] f;
    f = {1'b0, d, 1'b0};
    for (int k = 0; k < 14; k++) sbit(f[k]);
  endtask : load
  // Sample late in the low phase: the bit lags the rise by the sync delay
  task automatic read_frame(output logic [13:0] f);
    far_oe = 1'b0;
    for (int k = 0; k < 14; k++) begin
      #50 pins[1] = 1'b1;
      #100 pins[1] = 1'b0;
      #40 f[k] = data_wire;
      #10;
    end
    far_oe = 1'b1;
  endtask : read_frame
endmodule : far_side

//--- tb/tb.sv
// Purpose: Self-checking bench for the sleep, wake and reset cause block.
// Assumes: Watchdog shortened to 50 cycles; 40 MHz clock.
// Notes: Serial walk of 1024 increments reaches the ID words.
`timescale 1ns/1ps
`include "sleep_wake_map.svh"
module tb;
  logic clk, sys_rst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q;
  logic prog_data_out_q, prog_data_oe_q, reset_pin_oe_q, core_rst_q;
  logic osc_en_q, port_hold_q, sleep_q, prog_mode_q;
  logic rst_n, dw, cw, rw, xw, ent;
  logic [1:0] cmp;
  logic [3:0] pv;
  logic [1:0] cv;
  logic [13:0] f;
  int n_errors = 0;
  int samples_checked = 0;
  sleep_wake_reset_cause #(.WDT_CYCLES(50)) uut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .external_reset_pin_n(rst_n), .prog_data_pin(dw),
    .prog_clock_pin(cw), .reset_capable_input_pin(rw), .extra_wake_pin(xw),
    .comparator1_output(cmp[0]), .comparator2_output(cmp[1]),
    .program_entry_high_level(ent), .prog_data_out_q(prog_data_out_q),
    .prog_data_oe_q(prog_data_oe_q), .reset_pin_oe_q(reset_pin_oe_q),
    .core_rst_q(core_rst_q), .osc_en_q(osc_en_q), .port_hold_q(port_hold_q),
    .sleep_q(sleep_q), .prog_mode_q(prog_mode_q));
  far_side far (.clk(clk), .dev_out(prog_data_out_q), .dev_oe(prog_data_oe_q),
    .rst_pin_n(rst_n), .data_wire(dw), .clock_pin(cw), .rc_pin(rw),
    .extra_pin(xw), .cmp(cmp), .entry_hi(ent));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Access and check tasks
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(name, {6'h0, reg_rdata_q}, {6'h0, exp});
  endtask : rd_chk
  // Waits for a core reset to start and end, within a bound
  task automatic wait_reset(input int lim);
    int n;
    n = 0;
    while (core_rst_q !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    while (core_rst_q !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("reset wait", 14'(n < lim), 14'h1);
    @(posedge clk);
  endtask : wait_reset
  task automatic go_sleep();
    wr(`REG_CMD, 8'h01);
    #1 chk("sleep", 14'(sleep_q), 14'h1);
    chk("osc", 14'(osc_en_q), 14'h0);
    chk("hold", 14'(port_hold_q), 14'h1);
  endtask : go_sleep
  task automatic prog_word(input logic [11:0] d, input logic [11:0] exp, input string name);
    far.cmd(`PCMD_LOAD);
    far.load(d);
    far.cmd(`PCMD_PROG);
    far.cmd(`PCMD_READ);
    far.read_frame(f);
    chk(name, f, {1'b0, exp, 1'b0});
  endtask : prog_word
  // ==========================================================
  // Watchdog
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pv = 4'h0;
    cv = 2'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(`REG_STATUS, 8'h18, "power-up status");
    rd_chk(`REG_CTRL, 8'h01, "ctrl reset");
    rd_chk(4'hF, 8'h00, "unmapped");
    wr(`REG_STATUS, 8'hFF);
    rd_chk(`REG_STATUS, 8'h18, "status write");
    wait_reset(200);
    rd_chk(`REG_STATUS, 8'h08, "awake timeout");
    chk("reset pin drive", 14'(reset_pin_oe_q), 14'h0);
    far.rst_pulse();
    wait_reset(50);
    rd_chk(`REG_STATUS, 8'h08, "awake reset pin");
    go_sleep();
    repeat (30) @(posedge clk);
    chk("early wake", 14'(sleep_q), 14'h1);
    wait_reset(100);
    rd_chk(`REG_STATUS, 8'h00, "timeout wake");
    wr(`REG_CTRL, 8'h00);
    go_sleep();
    far.rst_pulse();
    wait_reset(50);
    rd_chk(`REG_STATUS, 8'h10, "reset pin wake");
    // Clears spaced under the timeout keep the core out of reset
    wr(`REG_CTRL, 8'h01);
    repeat (3) begin
      repeat (30) @(posedge clk);
      wr(`REG_CMD, 8'h02);
    end
    rd_chk(`REG_STATUS, 8'h10, "cleared watchdog");
    wr(`REG_CTRL, 8'h02);
    for (int i = 0; i < 4; i++) begin
      rd_chk(`REG_PORT, {4'h0, pv}, "port");
      go_sleep();
      far.pin_set(i, 1'b1);
      pv[i] = 1'b1;
      wait_reset(50);
      rd_chk(`REG_STATUS, 8'h90, "pin wake");
    end
    // Mismatch made after the snapshot, before sleep
    rd_chk(`REG_PORT, 8'h0F, "port");
    far.pin_set(0, 1'b0);
    far.pin_set(1, 1'b0);
    far.pin_set(3, 1'b0);
    pv = 4'h4;
    repeat (4) @(posedge clk);
    go_sleep();
    wait_reset(12);
    rd_chk(`REG_STATUS, 8'h90, "stale wake");
    wr(`REG_CTRL, 8'h04);
    rd_chk(`REG_PORT, {4'h0, pv}, "port");
    go_sleep();
    far.pin_set(3, 1'b1);
    repeat (20) @(posedge clk);
    chk("disabled wake", 14'(sleep_q), 14'h1);
    far.rst_pulse();
    wait_reset(50);
    rd_chk(`REG_STATUS, 8'h10, "reset pin wake");
    for (int i = 0; i < 2; i++) begin
      rd_chk(`REG_CMP1, {7'h0, cv[0]}, "cmp1");
      rd_chk(`REG_CMP2, {7'h0, cv[1]}, "cmp2");
      go_sleep();
      far.cmp_set(i, 1'b1);
      cv[i] = 1'b1;
      wait_reset(50);
      rd_chk(`REG_STATUS, 8'h50, "cmp wake");
    end
    // Protected part: free words, calibration word and IDs only
    wr(`REG_CTRL, 8'h08);
    far.pin_set(2, 1'b0);
    far.enter();
    repeat (8) @(posedge clk);
    chk("prog mode", 14'(prog_mode_q), 14'h1);
    chk("core held", 14'(core_rst_q), 14'h1);
    prog_word(12'hA5C, 12'hA5C, "word 0");
    repeat (64) far.cmd(`PCMD_INC);
    prog_word(12'h3C3, 12'h000, "word 64");
    // Same word readable once protection is off
    wr(`REG_CTRL, 8'h00);
    far.cmd(`PCMD_READ);
    far.read_frame(f);
    chk("open word 64", f, {1'b0, 12'h3C3, 1'b0});
    wr(`REG_CTRL, 8'h08);
    repeat (959) far.cmd(`PCMD_INC);
    prog_word(12'h5A3, 12'h5A3, "cal word");
    far.cmd(`PCMD_INC);
    prog_word(12'hFF5, 12'h0F5, "id word");
    far.leave();
    repeat (8) @(posedge clk);
    chk("prog exit", 14'(prog_mode_q), 14'h0);
    test_done();
  end
endmodule : tb
